// file: common/ptp_cmp_defs.svh
// Constants of the time-target compare block: offsets, reset values, fields.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PTP_CMP_DEFS_SVH
`define PTP_CMP_DEFS_SVH

// Register byte offsets
`define OFF_TGT_UP    12'h17c
`define OFF_TGT_LO    12'h180
`define OFF_RLD_UP    12'h184
`define OFF_RLD_LO    12'h188
`define OFF_UADDR_UP  12'h18c
`define OFF_UADDR_LO  12'h190
`define OFF_CTRL      12'h1a0
`define OFF_ISTAT     12'h1a4
`define OFF_IMASK     12'h1a8

// Reset values and masks
`define RST_WORD      32'h0000_0000
`define RST_HALF      16'h0000
`define RST_CTRL      4'h0
`define RST_BIT       1'b0
`define RST_REACHED   1'b1
`define UADDR_UP_W    16

// Control register fields
`define CTRL_RELOAD_BIT 0
`define CTRL_UEN_LSB    1
`define CTRL_W          4
`define NUM_PORTS       3

// Interrupt fields
`define ISTAT_CMP_BIT 0

// AXI responses
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

`endif

// file: common/ptp_cmp_pkg.sv
// Types and shared helpers of the time-target compare block.
// Assumes the constants header sits on the include path.
`include "ptp_cmp_defs.svh"

package ptp_cmp_pkg;

	// Write channel states
	typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_t;

	// Read channel states
	typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} rd_state_t;

	// One-hot register select
	typedef enum logic [9:0] {
		SEL_NONE     = 10'h001,
		SEL_TGT_UP   = 10'h002,
		SEL_TGT_LO   = 10'h004,
		SEL_RLD_UP   = 10'h008,
		SEL_RLD_LO   = 10'h010,
		SEL_UADDR_UP = 10'h020,
		SEL_UADDR_LO = 10'h040,
		SEL_CTRL     = 10'h080,
		SEL_ISTAT    = 10'h100,
		SEL_IMASK    = 10'h200
	} reg_sel_t;

	// Destination address of a frame seen on one port
	typedef struct packed {
		logic        valid;
		logic [47:0] dest;
	} frame_addr_t;

	// Word address to register select
	function automatic reg_sel_t decode_addr(input logic [11:0] addr);
		case ({addr[11:2], 2'b00})
			`OFF_TGT_UP:   decode_addr = SEL_TGT_UP;
			`OFF_TGT_LO:   decode_addr = SEL_TGT_LO;
			`OFF_RLD_UP:   decode_addr = SEL_RLD_UP;
			`OFF_RLD_LO:   decode_addr = SEL_RLD_LO;
			`OFF_UADDR_UP: decode_addr = SEL_UADDR_UP;
			`OFF_UADDR_LO: decode_addr = SEL_UADDR_LO;
			`OFF_CTRL:     decode_addr = SEL_CTRL;
			`OFF_ISTAT:    decode_addr = SEL_ISTAT;
			`OFF_IMASK:    decode_addr = SEL_IMASK;
			default:       decode_addr = SEL_NONE;
		endcase
	endfunction

	// Merge new data into an old word under byte strobes
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			merge_bytes[i*8 +: 8] = strb[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
	endfunction

endpackage

// file: rtl/user_addr_match.sv
// Per-port recogniser of the user station address in frame headers.
// Assumes frame headers come from logic on sys_clk; no synchroniser needed.
`timescale 1ns/100ps
`default_nettype none

module user_addr_match
	import ptp_cmp_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Frame and settings
	input  wire frame_addr_t frame,
	input  wire logic [47:0] user_addr,
	input  wire logic        enable,
	// Result
	output logic             hit
);

	logic hit_next; // Match seen this cycle

	// Match only while this port has the user address switched on
	always_comb
	begin
		hit_next = frame.valid & enable & (frame.dest == user_addr);
	end

	// Register the result
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			hit <= `RST_BIT;
		else
			hit <= hit_next;
	end

endmodule // user_addr_match

`default_nettype wire

// file: rtl/ptp_clock_target_compare.sv
// Compare and reload logic of the 64-bit time clock, with user station address.
// Assumes time_now and frame headers are on sys_clk; AXI4-Lite slave.
//
// How it works
// - Compare target with clock; match raises event
// - Lower target word, read-write, resets zero
// - Upper target word supplies high 32 bits
// - Written target takes effect only after both halves written
// - Reload value: two read-write words, reset zero
// - Reload mode copies reload into target
// - Mode bit picks replace or add
// - Reload changes only after both halves written
// - 48-bit user address from two registers
// - Upper address bits 31:16 read zero
// - User address used only where port enabled
// - Enabled port flags frames carrying user address
//
// The AXI4-Lite interface to the registers was decided locally.
`include "ptp_cmp_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module ptp_clock_target_compare
	import ptp_cmp_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// AXI4-Lite write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Running time clock
	input  wire logic [63:0] time_now,
	// Frame headers per port
	input  wire frame_addr_t port_frame [`NUM_PORTS],
	// Events
	output logic             compare_event,
	output logic             irq,
	output logic [2:0]       user_addr_hit
);

	// Write channel state
	wr_state_t   wr_state_reg, wr_state_next;   // Write phase
	logic        aw_have_reg, aw_have_next;     // Address held
	logic        w_have_reg, w_have_next;       // Data held
	logic [11:0] awaddr_reg, awaddr_next;       // Held address
	logic [31:0] wdata_reg, wdata_next;         // Held data
	logic [3:0]  wstrb_reg, wstrb_next;         // Held strobes
	logic        awready_next, wready_next;     // Ready next values
	logic        bvalid_next;                   // Response valid next
	logic [1:0]  bresp_next;                    // Response code next
	logic        wr_fire;                       // Register write this cycle
	reg_sel_t    wr_sel;                        // Write target

	// Read channel state
	rd_state_t   rd_state_reg, rd_state_next;   // Read phase
	logic        arready_next, rvalid_next;     // Handshake next values
	logic [31:0] rdata_next;                    // Read word next
	logic [1:0]  rresp_next;                    // Read code next

	// Register file
	logic [31:0] tgt_up_reg, tgt_up_next;       // Staged upper target
	logic [31:0] tgt_lo_reg, tgt_lo_next;       // Staged lower target
	logic        tgt_up_wr_reg, tgt_up_wr_next; // Upper half written
	logic        tgt_lo_wr_reg, tgt_lo_wr_next; // Lower half written
	logic [31:0] rld_up_reg, rld_up_next;       // Staged upper reload
	logic [31:0] rld_lo_reg, rld_lo_next;       // Staged lower reload
	logic        rld_up_wr_reg, rld_up_wr_next; // Upper half written
	logic        rld_lo_wr_reg, rld_lo_wr_next; // Lower half written
	logic [15:0] uaddr_up_reg, uaddr_up_next;   // User address high
	logic [31:0] uaddr_lo_reg, uaddr_lo_next;   // User address low
	logic [`CTRL_W-1:0] ctrl_reg, ctrl_next;    // Mode and port enables
	logic        istat_reg, istat_next;         // Sticky compare status
	logic        imask_reg, imask_next;         // Interrupt enable
	logic        irq_next;                      // Interrupt level next
	logic [31:0] wr_word;                       // Strobed write data

	// Compare engine
	logic [63:0] target_reg, target_next;       // Active compare target
	logic [63:0] reload_reg, reload_next;       // Active reload value
	logic        reached_reg, reached_next;     // Clock at or past target
	logic        event_now;                     // Crossing this cycle
	logic [47:0] user_addr;                     // Full user address

	// Write channel: collect address and data in either order
	always_comb
	begin
		wr_state_next = wr_state_reg;
		aw_have_next  = aw_have_reg;
		w_have_next   = w_have_reg;
		awaddr_next   = awaddr_reg;
		wdata_next    = wdata_reg;
		wstrb_next    = wstrb_reg;
		bvalid_next   = s_axi_bvalid;
		bresp_next    = s_axi_bresp;
		wr_fire       = 1'b0;
		wr_sel        = decode_addr(awaddr_reg);
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_have_next = 1'b1;
			awaddr_next  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_have_next = 1'b1;
			wdata_next  = s_axi_wdata;
			wstrb_next  = s_axi_wstrb;
		end
		case (wr_state_reg)
			WR_IDLE:
			begin
				// Both parts held: commit one cycle later than the last handshake
				if (aw_have_reg && w_have_reg)
				begin
					wr_fire       = 1'b1;
					aw_have_next  = 1'b0;
					w_have_next   = 1'b0;
					bvalid_next   = 1'b1;
					bresp_next    = (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
					wr_state_next = WR_RESP;
				end
			end
			WR_RESP:
			begin
				// Hold response until the master takes it
				if (s_axi_bready)
				begin
					bvalid_next   = 1'b0;
					wr_state_next = WR_IDLE;
				end
			end
			default:
				wr_state_next = WR_IDLE;
		endcase
		awready_next = (wr_state_next == WR_IDLE) && !aw_have_next;
		wready_next  = (wr_state_next == WR_IDLE) && !w_have_next;
	end

	// Write channel registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			wr_state_reg  <= WR_IDLE;
			aw_have_reg   <= `RST_BIT;
			w_have_reg    <= `RST_BIT;
			awaddr_reg    <= '0;
			wdata_reg     <= `RST_WORD;
			wstrb_reg     <= '0;
			s_axi_awready <= `RST_BIT;
			s_axi_wready  <= `RST_BIT;
			s_axi_bvalid  <= `RST_BIT;
			s_axi_bresp   <= `RESP_OKAY;
		end
		else
		begin
			wr_state_reg  <= wr_state_next;
			aw_have_reg   <= aw_have_next;
			w_have_reg    <= w_have_next;
			awaddr_reg    <= awaddr_next;
			wdata_reg     <= wdata_next;
			wstrb_reg     <= wstrb_next;
			s_axi_awready <= awready_next;
			s_axi_wready  <= wready_next;
			s_axi_bvalid  <= bvalid_next;
			s_axi_bresp   <= bresp_next;
		end
	end

	// Register file, pairing and compare engine
	always_comb
	begin
		tgt_up_next    = tgt_up_reg;
		tgt_lo_next    = tgt_lo_reg;
		tgt_up_wr_next = tgt_up_wr_reg;
		tgt_lo_wr_next = tgt_lo_wr_reg;
		rld_up_next    = rld_up_reg;
		rld_lo_next    = rld_lo_reg;
		rld_up_wr_next = rld_up_wr_reg;
		rld_lo_wr_next = rld_lo_wr_reg;
		uaddr_up_next  = uaddr_up_reg;
		uaddr_lo_next  = uaddr_lo_reg;
		ctrl_next      = ctrl_reg;
		imask_next     = imask_reg;
		target_next    = target_reg;
		reload_next    = reload_reg;
		wr_word        = `RST_WORD;
		// Level of clock against target; edge of it is the event
		reached_next   = (time_now >= target_reg);
		event_now      = reached_next && !reached_reg;
		// Hardware update of the target; a software commit below overrides it
		if (event_now)
		begin
			if (ctrl_reg[`CTRL_RELOAD_BIT])
				target_next = reload_reg;
			else
				target_next = target_reg + reload_reg;
		end
		// Software writes
		if (wr_fire)
		begin
			case (wr_sel)
				SEL_TGT_UP:
				begin
					tgt_up_next    = merge_bytes(tgt_up_reg, wdata_reg, wstrb_reg);
					tgt_up_wr_next = 1'b1;
				end
				SEL_TGT_LO:
				begin
					tgt_lo_next    = merge_bytes(tgt_lo_reg, wdata_reg, wstrb_reg);
					tgt_lo_wr_next = 1'b1;
				end
				SEL_RLD_UP:
				begin
					rld_up_next    = merge_bytes(rld_up_reg, wdata_reg, wstrb_reg);
					rld_up_wr_next = 1'b1;
				end
				SEL_RLD_LO:
				begin
					rld_lo_next    = merge_bytes(rld_lo_reg, wdata_reg, wstrb_reg);
					rld_lo_wr_next = 1'b1;
				end
				SEL_UADDR_UP:
				begin
					// Upper half of the word is not stored
					wr_word       = merge_bytes({16'h0000, uaddr_up_reg}, wdata_reg, wstrb_reg);
					uaddr_up_next = wr_word[`UADDR_UP_W-1:0];
				end
				SEL_UADDR_LO:
					uaddr_lo_next = merge_bytes(uaddr_lo_reg, wdata_reg, wstrb_reg);
				SEL_CTRL:
				begin
					wr_word   = merge_bytes({28'h0000000, ctrl_reg}, wdata_reg, wstrb_reg);
					ctrl_next = wr_word[`CTRL_W-1:0];
				end
				SEL_IMASK:
				begin
					wr_word    = merge_bytes({31'h00000000, imask_reg}, wdata_reg, wstrb_reg);
					imask_next = wr_word[`ISTAT_CMP_BIT];
				end
				default:
					wr_word = `RST_WORD;
			endcase
		end
		// Both target halves in: commit as one 64-bit value
		if (tgt_up_wr_next && tgt_lo_wr_next)
		begin
			target_next    = {tgt_up_next, tgt_lo_next};
			tgt_up_wr_next = 1'b0;
			tgt_lo_wr_next = 1'b0;
		end
		// Both reload halves in: commit as one 64-bit value
		if (rld_up_wr_next && rld_lo_wr_next)
		begin
			reload_next    = {rld_up_next, rld_lo_next};
			rld_up_wr_next = 1'b0;
			rld_lo_wr_next = 1'b0;
		end
		// Sticky status: a new event wins over a write-one clear
		istat_next = istat_reg;
		if (wr_fire && wr_sel == SEL_ISTAT && wstrb_reg[0] && wdata_reg[`ISTAT_CMP_BIT])
			istat_next = 1'b0;
		if (event_now)
			istat_next = 1'b1;
		irq_next = istat_next & imask_next;
	end

	// Register file and compare registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			tgt_up_reg    <= `RST_WORD;
			tgt_lo_reg    <= `RST_WORD;
			tgt_up_wr_reg <= `RST_BIT;
			tgt_lo_wr_reg <= `RST_BIT;
			rld_up_reg    <= `RST_WORD;
			rld_lo_reg    <= `RST_WORD;
			rld_up_wr_reg <= `RST_BIT;
			rld_lo_wr_reg <= `RST_BIT;
			uaddr_up_reg  <= `RST_HALF;
			uaddr_lo_reg  <= `RST_WORD;
			ctrl_reg      <= `RST_CTRL;
			istat_reg     <= `RST_BIT;
			imask_reg     <= `RST_BIT;
			target_reg    <= {`RST_WORD, `RST_WORD};
			reload_reg    <= {`RST_WORD, `RST_WORD};
			// Held high so a zero target does not fire at reset release
			reached_reg   <= `RST_REACHED;
			compare_event <= `RST_BIT;
			irq           <= `RST_BIT;
		end
		else
		begin
			tgt_up_reg    <= tgt_up_next;
			tgt_lo_reg    <= tgt_lo_next;
			tgt_up_wr_reg <= tgt_up_wr_next;
			tgt_lo_wr_reg <= tgt_lo_wr_next;
			rld_up_reg    <= rld_up_next;
			rld_lo_reg    <= rld_lo_next;
			rld_up_wr_reg <= rld_up_wr_next;
			rld_lo_wr_reg <= rld_lo_wr_next;
			uaddr_up_reg  <= uaddr_up_next;
			uaddr_lo_reg  <= uaddr_lo_next;
			ctrl_reg      <= ctrl_next;
			istat_reg     <= istat_next;
			imask_reg     <= imask_next;
			target_reg    <= target_next;
			reload_reg    <= reload_next;
			reached_reg   <= reached_next;
			compare_event <= event_now;
			irq           <= irq_next;
		end
	end

	// Read channel: one word answered the cycle after the address is taken
	always_comb
	begin
		rd_state_next = rd_state_reg;
		rvalid_next   = s_axi_rvalid;
		rdata_next    = s_axi_rdata;
		rresp_next    = s_axi_rresp;
		case (rd_state_reg)
			RD_IDLE:
			begin
				if (s_axi_arvalid && s_axi_arready)
				begin
					rvalid_next   = 1'b1;
					rresp_next    = `RESP_OKAY;
					rd_state_next = RD_RESP;
					case (decode_addr(s_axi_araddr))
						SEL_TGT_UP:   rdata_next = tgt_up_reg;
						SEL_TGT_LO:   rdata_next = tgt_lo_reg;
						SEL_RLD_UP:   rdata_next = rld_up_reg;
						SEL_RLD_LO:   rdata_next = rld_lo_reg;
						SEL_UADDR_UP: rdata_next = {16'h0000, uaddr_up_reg};
						SEL_UADDR_LO: rdata_next = uaddr_lo_reg;
						SEL_CTRL:     rdata_next = {28'h0000000, ctrl_reg};
						SEL_ISTAT:    rdata_next = {31'h00000000, istat_reg};
						SEL_IMASK:    rdata_next = {31'h00000000, imask_reg};
						default:
						begin
							// Unmapped: zero data, slave error
							rdata_next = `RST_WORD;
							rresp_next = `RESP_SLVERR;
						end
					endcase
				end
			end
			RD_RESP:
			begin
				if (s_axi_rready)
				begin
					rvalid_next   = 1'b0;
					rd_state_next = RD_IDLE;
				end
			end
			default:
				rd_state_next = RD_IDLE;
		endcase
		arready_next = (rd_state_next == RD_IDLE);
	end

	// Read channel registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rd_state_reg  <= RD_IDLE;
			s_axi_arready <= `RST_BIT;
			s_axi_rvalid  <= `RST_BIT;
			s_axi_rdata   <= `RST_WORD;
			s_axi_rresp   <= `RESP_OKAY;
		end
		else
		begin
			rd_state_reg  <= rd_state_next;
			s_axi_arready <= arready_next;
			s_axi_rvalid  <= rvalid_next;
			s_axi_rdata   <= rdata_next;
			s_axi_rresp   <= rresp_next;
		end
	end

	// Full 48-bit station address
	assign user_addr = {uaddr_up_reg, uaddr_lo_reg};

	// One recogniser per port, each gated by its own enable bit
	for (genvar p = 0; p < `NUM_PORTS; p++)
	begin : g_port
		user_addr_match u_match (
			.sys_clk   (sys_clk),
			.rst       (rst),
			.frame     (port_frame[p]),
			.user_addr (user_addr),
			.enable    (ctrl_reg[`CTRL_UEN_LSB + p]),
			.hit       (user_addr_hit[p])
		);
	end

endmodule // ptp_clock_target_compare

`default_nettype wire

// file: test/ptp_clock_target_compare_sva.sv
// Checker of the time-target compare block, bound to its top module.
// Assumes the package is compiled first; sees top-level ports only.
`include "ptp_cmp_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module ptp_cmp_checker
	import ptp_cmp_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Frames and events
	input wire frame_addr_t port_frame [`NUM_PORTS],
	input wire logic        compare_event,
	input wire logic        irq,
	input wire logic [2:0]  user_addr_hit
);
	// Single domain, so one default clock and reset
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Taken read address handshake
	wire ar_hs = s_axi_arvalid && s_axi_arready;

	// Event is one cycle long; a held level would mean one event per cycle
	property p_evt_pulse; compare_event |=> !compare_event; endproperty
	a_evt_pulse: assert property (p_evt_pulse) else $error("event wider than one cycle");
	// A hit on port 0 or port 2 only follows a frame header on that port
	property p_hit0; user_addr_hit[0] |-> $past(port_frame[0].valid); endproperty
	a_hit0: assert property (p_hit0) else $error("port 0 hit without frame");
	property p_hit2; user_addr_hit[2] |-> $past(port_frame[2].valid); endproperty
	a_hit2: assert property (p_hit2) else $error("port 2 hit without frame");
	// Reserved upper half of the address word reads zero
	property p_upper_rsvd; ar_hs && s_axi_araddr[11:2] == 10'h063 |=> s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_upper_rsvd: assert property (p_upper_rsvd) else $error("reserved bits not zero");
	// Unmapped read answers error with zero data
	property p_unmapped; ar_hs && s_axi_araddr[11:2] > 10'h06a
		|=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0000_0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	// Read data one edge after the address is taken
	property p_rd_lat; ar_hs |=> s_axi_rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	// Write answer exactly two edges after both channels are taken
	property p_wr_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer timing wrong");
	// Read answer stands until taken
	property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
	// Write answer stands until taken
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");

	// Interrupt rises only with an event, or with the answer of a mask or status write
	property p_irq_src; $rose(irq) |-> compare_event || $rose(s_axi_bvalid); endproperty
	a_irq_src: assert property (p_irq_src) else $error("irq rose without cause");

	// Main scenarios reached
	c_evt: cover property (compare_event);
	c_irq: cover property ($rose(irq));
	c_hit2: cover property (user_addr_hit[2]);
	c_err: cover property (ar_hs && s_axi_araddr[11:2] > 10'h06a);
endmodule // ptp_cmp_checker

bind ptp_clock_target_compare ptp_cmp_checker u_chk (.sys_clk, .rst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .port_frame, .compare_event, .irq,
	.user_addr_hit);

`default_nettype wire

// file: test/ptp_clock_target_compare_tb_top.sv
// Self-checking bench of the time-target compare block.
// Assumes package, design and checker are compiled before it.
`include "ptp_cmp_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module ptp_clock_target_compare_tb_top
	import ptp_cmp_pkg::*;
;
	logic        sys_clk, rst;                      // Clock, reset
	logic [11:0] s_axi_awaddr, s_axi_araddr;        // Bus addresses
	logic [31:0] s_axi_wdata, s_axi_rdata;          // Bus data
	logic [3:0]  s_axi_wstrb;                       // Byte lanes
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;        // Read handshake
	logic [1:0]  s_axi_bresp, s_axi_rresp;          // Responses
	logic [63:0] time_now;                          // Running time
	frame_addr_t port_frame [`NUM_PORTS];           // Frame headers
	logic        compare_event, irq;                // Events
	logic [2:0]  user_addr_hit;                     // Per-port hits
	int          error_cnt, tests_run, cyc;         // Counters
	logic [47:0] ua = 48'h1234_5678_9abc;           // User address

	ptp_clock_target_compare uut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .time_now, .port_frame, .compare_event, .irq,
		.user_addr_hit);

	// 125 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Value compare; four-state so unknowns fail
	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask

	// Bus write; both channels offered together, each released when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge sys_clk);
			if (s_axi_awready && !aw_done)
			begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !w_done)
			begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", er, s_axi_bresp);
	endtask

	// Bus read with expected data and response
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rdata", ed, s_axi_rdata);
		chk("rresp", er, s_axi_rresp);
	endtask

	// Step the clock value, then count events over four edges
	task automatic tstep(input logic [63:0] t, input int n);
		int cnt;
		cnt = 0;
		@(posedge sys_clk);
		time_now <= t;
		repeat (4)
		begin
			@(posedge sys_clk);
			cnt += int'(compare_event === 1'b1);
		end
		chk("event count", n, cnt);
	endtask

	// One header on every port, hits seen one cycle later
	task automatic frame(input logic [47:0] d, input logic [2:0] eh);
		@(posedge sys_clk);
		foreach (port_frame[i]) port_frame[i] <= '{1'b1, d};
		@(posedge sys_clk);
		foreach (port_frame[i]) port_frame[i].valid <= 1'b0;
		@(posedge sys_clk);
		chk("user_addr_hit", eh, user_addr_hit);
	endtask

	// Reset values of all words, and refusal of an unmapped place
	task automatic t_reset;
		logic [11:0] offs [9] = '{`OFF_TGT_UP, `OFF_TGT_LO, `OFF_RLD_UP, `OFF_RLD_LO,
			`OFF_UADDR_UP, `OFF_UADDR_LO, `OFF_CTRL, `OFF_ISTAT, `OFF_IMASK};
		foreach (offs[i]) rd(offs[i], `RST_WORD, `RESP_OKAY);
		rd(12'h1b0, 32'h0000_0000, `RESP_SLVERR);
		wr(12'h1b0, 32'h0000_0001, `RESP_SLVERR);
	endtask

	// Half-written target stays inactive; crossings fire once
	task automatic t_target;
		wr(`OFF_TGT_LO, 32'd50, `RESP_OKAY);
		tstep(64'd10, 0);
		tstep(64'd60, 0);
		wr(`OFF_TGT_UP, 32'd0, `RESP_OKAY);
		tstep(64'd10, 0);
		tstep(64'd50, 1);
		tstep(64'd60, 0);
		rd(`OFF_TGT_LO, 32'd50, `RESP_OKAY);
	endtask

	// Reload pairing, then add mode and replace mode
	task automatic t_reload;
		wr(`OFF_RLD_LO, 32'd100, `RESP_OKAY);
		tstep(64'd10, 0);
		tstep(64'd50, 1);
		tstep(64'd10, 0);
		tstep(64'd50, 1);
		wr(`OFF_RLD_UP, 32'd0, `RESP_OKAY);
		rd(`OFF_RLD_LO, 32'd100, `RESP_OKAY);
		tstep(64'd10, 0);
		tstep(64'd50, 1);
		tstep(64'd149, 0);
		tstep(64'd150, 1);
		wr(`OFF_CTRL, 32'h0000_0001, `RESP_OKAY);
		tstep(64'd249, 0);
		tstep(64'd250, 1);
		tstep(64'd99, 0);
		tstep(64'd100, 1);
	endtask

	// Interrupt raised, cleared and masked
	task automatic t_irq;
		wr(`OFF_ISTAT, 32'h0000_0001, `RESP_OKAY);
		rd(`OFF_ISTAT, 32'h0000_0000, `RESP_OKAY);
		wr(`OFF_IMASK, 32'h0000_0001, `RESP_OKAY);
		tstep(64'd99, 0);
		tstep(64'd100, 1);
		chk("irq", 1'b1, irq);
		wr(`OFF_ISTAT, 32'h0000_0001, `RESP_OKAY);
		@(posedge sys_clk);
		chk("irq", 1'b0, irq);
		wr(`OFF_IMASK, 32'h0000_0000, `RESP_OKAY);
		tstep(64'd99, 0);
		tstep(64'd100, 1);
		chk("irq", 1'b0, irq);
		rd(`OFF_ISTAT, 32'h0000_0001, `RESP_OKAY);
	endtask

	// User address: reserved bits, per-port enables, near miss
	task automatic t_uaddr;
		wr(`OFF_UADDR_UP, 32'hffff_1234, `RESP_OKAY);
		rd(`OFF_UADDR_UP, 32'h0000_1234, `RESP_OKAY);
		wr(`OFF_UADDR_LO, 32'h5678_0000, `RESP_OKAY);
		// Lanes 1:0 only; the upper lanes must keep their old bytes
		s_axi_wstrb <= 4'h3;
		wr(`OFF_UADDR_LO, 32'hffff_9abc, `RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(`OFF_UADDR_LO, 32'h5678_9abc, `RESP_OKAY);
		frame(ua, 3'b000);
		wr(`OFF_CTRL, 32'h0000_0009, `RESP_OKAY);
		frame(ua, 3'b100);
		frame(ua ^ 48'h1, 3'b000);
		wr(`OFF_CTRL, 32'h0000_000f, `RESP_OKAY);
		frame(ua, 3'b111);
	endtask

	// Counts, verdict, end of run
	task automatic results;
		$display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard; the run needs well under a thousand cycles
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			results();
		end
	end

	// Main sequence
	initial
	begin
		rst = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		time_now = 64'h0;
		foreach (port_frame[i]) port_frame[i] = '0;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_target();
		t_reload();
		t_irq();
		t_uaddr();
		results();
	end
endmodule // ptp_clock_target_compare_tb_top

`default_nettype wire
